// >>> logic/scf_pkg.sv
// constants, register map and mode type of the spi command front end
package scf_pkg;
    // frame geometry
    localparam int FRAME_BITS = 16;
    localparam int ACCESS_BIT = 7;
    // control register addresses
    localparam logic [6:0] ADDR_MODE_SUPPLY = 7'h01;
    localparam logic [6:0] ADDR_HW_CONFIG = 7'h02;
    localparam logic [6:0] ADDR_WATCHDOG = 7'h03;
    localparam logic [6:0] ADDR_BUS_ONE = 7'h04;
    localparam logic [6:0] ADDR_BUS_TWO = 7'h05;
    localparam logic [6:0] ADDR_WAKE_ONE = 7'h06;
    localparam logic [6:0] ADDR_WAKE_TWO = 7'h07;
    localparam logic [6:0] ADDR_WAKE_PULL = 7'h08;
    localparam logic [6:0] ADDR_TIMER = 7'h0c;
    localparam logic [6:0] ADDR_SCRATCH = 7'h1e;
    localparam logic [6:0] ADDR_CTRL_LO = 7'h01;
    localparam logic [6:0] ADDR_CTRL_HI = 7'h1e;
    // status register addresses, index i feeds summary bit i
    localparam logic [7:0][6:0] STAT_ADDR = {7'h4c, 7'h47, 7'h46, 7'h45,
                                             7'h44, 7'h43, 7'h42, 7'h41};
    localparam logic [6:0] ADDR_WAKE_LEVEL = 7'h48;
    localparam logic [6:0] ADDR_FAMILY_ID = 7'h7e;
    localparam logic [6:0] ADDR_STAT_LO = 7'h41;
    localparam logic [6:0] ADDR_STAT_HI = 7'h7e;
    // status indexes and field positions
    localparam int STAT_SUPPLY = 0;
    localparam int STAT_DEVICE = 2;
    localparam int CMD_FAIL_BIT = 1;
    localparam int MODE_LSB = 6;
    localparam int AUX_LSB = 3;
    // mode field codes
    localparam logic [1:0] MODE_CODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_CODE_SLEEP = 2'h1;
    localparam logic [1:0] MODE_CODE_STOP = 2'h2;
    localparam logic [1:0] MODE_CODE_RESET = 2'h3;
    // transceiver field codes
    localparam logic [1:0] TRX_ON = 2'h3;
    localparam logic [1:0] TRX_WAKE = 2'h1;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] SUPPLY_RESET = 8'h80;
    // operating modes
    typedef enum logic [2:0] {
        MODE_INIT,
        MODE_NORMAL,
        MODE_STOP,
        MODE_SLEEP,
        MODE_RESTART,
        MODE_FAILSAFE
    } scf_mode_t;
endpackage : scf_pkg

// >>> logic/scf_sync.sv
// two flip-flop synchroniser for pins entering the system clock domain
`timescale 1ns/100ps
module scf_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    // first stage, read only by the second stage
    logic [WIDTH-1:0] meta_q;

    // both stages reset to the idle pin level
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            meta_q <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : scf_sync

// >>> logic/scf_frontend.sv
// spi command front end: frame checks, register file, mode requests
//
// Summary of operation
// R1 - stop to sleep request fails, restart
// R2 - stop/sleep from init fails, go normal
// R3 - stop mode accepts only limited commands
// R4 - sleep without wake sources fails, restart
// R5 - stop without wake sources is accepted
// R6 - only zero or sixteen clocks accepted
// R7 - clock high at select edge voids frame
// R8 - frame error shown high before first clock
// R9 - empty frame reads error, sets none
// R10 - address 6:0, access bit 7, data 15:8
// R11 - access bit writes control, clears status
// R12 - restart, sleep, failsafe ignore all frames
// R13 - status flags hold until host clears
// R14 - status contents returned same frame
// R15 - control returns value before the frame
// R16 - summary byte is or of status registers
// R17 - summary clears when register all zero
// R18 - control and status address ranges decoded
// R19 - wake level register live, never cleared
// R20 - mode field reports actual mode (code reads init, restart and failsafe as normal)
// R21 - sleep entry turns active transceivers wake-capable
// R22 - auxiliary supply configured in normal only
// R23 - sample on falling, shift on rising clock
// R24 - decode at select rise, release data out
// R25 - mode codes normal sleep stop softreset
// R26 - command fail flag held until cleared
// R27 - unmapped access changes nothing, reads zero
`timescale 1ns/100ps
module scf_frontend #(
    parameter logic [7:0] FAMILY_ID = 8'h5a  // arbitrary identity value
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe_n,
    input wire logic wake_input,
    input wire logic [7:0][7:0] status_set,
    input wire logic wake_event,
    input wire logic restart_done,
    input wire logic failsafe_enter,
    input wire logic failsafe_leave,
    output scf_pkg::scf_mode_t mode_q,
    output logic soft_reset_q,
    output logic watchdog_trigger_q,
    output logic [1:0] auxiliary_supply_q,
    output logic [7:0] hardware_config_q,
    output logic [7:0] watchdog_config_q,
    output logic [7:0] bus_control_one_q,
    output logic [7:0] bus_control_two_q
);
    // synchronised pins: wake, sdi, cs_n, clk
    logic [3:0] pins_s;
    logic clk_s;
    logic cs_s;
    logic sdi_s;
    logic wake_s;
    // delayed copies for edge detection
    logic clk_d_q;
    logic cs_d_q;
    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_rise;
    logic in_frame;
    // frame state
    logic [4:0] bit_cnt_q;
    logic [15:0] rx_q;
    logic edge_err_q;
    logic err_pend_q;
    logic [3:0] out_idx_q;
    logic [7:0] sum_snap_q;
    logic [7:0] rdata_q;
    // response word as shifted out, summary in the low byte
    logic [15:0] out_word;
    // remaining control registers
    logic [2:0] supply_misc_q;
    logic [7:0] wake_one_q;
    logic [7:0] wake_two_q;
    logic [7:0] wake_pull_q;
    logic [7:0] timer_q;
    logic [7:0] scratch_q;
    // status registers and summary
    logic [7:0][7:0] stat_q;
    logic [7:0] summary;
    logic [7:0] clr;
    logic [7:0] rd_mux;
    // command decode
    logic [6:0] c_addr;
    logic c_wr;
    logic [7:0] c_data;
    logic frame_good;
    logic accept;
    logic ctrl_wr;
    logic wr_ok;
    logic fail;
    logic soft_rst;
    logic no_wake;
    logic [1:0] mode_code;
    scf_pkg::scf_mode_t mode_d;

    scf_sync #(
        .WIDTH(4),
        .RESET_VALUE(4'h2)
    ) u_pin_sync (
        .clock(clock),
        .reset_n(reset_n),
        .async_in({wake_input, spi_sdi, spi_cs_n, spi_clk}),
        .sync_out(pins_s)
    );

    assign {wake_s, sdi_s, cs_s, clk_s} = pins_s;

    // edge history of the synchronised clock and select
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            clk_d_q <= 1'b0;
            cs_d_q <= 1'b1;
        end
        else
        begin
            clk_d_q <= clk_s;
            cs_d_q <= cs_s;
        end
    end

    assign sclk_rise = clk_s & ~clk_d_q;
    assign sclk_fall = ~clk_s & clk_d_q;
    assign cs_fall = ~cs_s & cs_d_q;
    assign cs_rise = cs_s & ~cs_d_q;
    assign in_frame = ~cs_s & ~cs_d_q;

    // frame fields, bit 0 arrives first
    assign c_addr = rx_q[6:0];  // R10
    assign c_wr = rx_q[scf_pkg::ACCESS_BIT];
    assign c_data = rx_q[15:8];

    // count clocks and shift in data on falling edges
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            bit_cnt_q <= 5'h00;
            rx_q <= 16'h0000;
        end
        else if (cs_fall)
        begin
            bit_cnt_q <= 5'h00;
        end
        else if (in_frame && sclk_fall)
        begin
            // saturate so that long frames still mismatch
            if (bit_cnt_q != 5'h1f)
            begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
            rx_q <= {sdi_s, rx_q[15:1]};  // R23
        end
    end

    // clock level at select edges and frame error bookkeeping
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            edge_err_q <= 1'b0;
            err_pend_q <= 1'b0;
        end
        else if (cs_fall)
        begin
            edge_err_q <= clk_s;  // R7
            err_pend_q <= 1'b0;
        end
        else if (cs_rise)
        begin
            // an empty frame with clean edges leaves the flag low
            err_pend_q <= edge_err_q | clk_s |  // R7 R9
                (bit_cnt_q != 5'h00 && bit_cnt_q != 5'(scf_pkg::FRAME_BITS));  // R6
        end
    end

    // summary bit per status register, reg index i to bit i
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            summary[i] = |stat_q[i];  // R16 R17
        end
    end

    // response data for the address already received
    always_comb
    begin
        rd_mux = 8'h00;  // R27
        case (rx_q[15:9])
            scf_pkg::ADDR_MODE_SUPPLY:
                rd_mux = {mode_code, 1'b0, auxiliary_supply_q, supply_misc_q};  // R20
            scf_pkg::ADDR_HW_CONFIG: rd_mux = hardware_config_q;
            scf_pkg::ADDR_WATCHDOG: rd_mux = watchdog_config_q;
            scf_pkg::ADDR_BUS_ONE: rd_mux = bus_control_one_q;
            scf_pkg::ADDR_BUS_TWO: rd_mux = bus_control_two_q;
            scf_pkg::ADDR_WAKE_ONE: rd_mux = wake_one_q;
            scf_pkg::ADDR_WAKE_TWO: rd_mux = wake_two_q;
            scf_pkg::ADDR_WAKE_PULL: rd_mux = wake_pull_q;
            scf_pkg::ADDR_TIMER: rd_mux = timer_q;
            scf_pkg::ADDR_SCRATCH: rd_mux = scratch_q;
            scf_pkg::ADDR_WAKE_LEVEL: rd_mux = {7'h00, wake_s};  // R19
            scf_pkg::ADDR_FAMILY_ID: rd_mux = FAMILY_ID;
            default:
            begin
                for (int i = 0; i < 8; i++)
                begin
                    if (rx_q[15:9] == scf_pkg::STAT_ADDR[i])
                    begin
                        rd_mux = stat_q[i];  // R14
                    end
                end
            end
        endcase
    end

    // a named word, since a concatenation cannot be bit-selected
    assign out_word = {rdata_q, sum_snap_q};

    // output shifter: summary then data, one bit per rising clock
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            out_idx_q <= 4'h0;
            sum_snap_q <= 8'h00;
            rdata_q <= 8'h00;
            spi_sdo <= 1'b0;
            spi_sdo_oe_n <= 1'b1;
        end
        else
        begin
            spi_sdo_oe_n <= cs_s;  // R24
            if (cs_fall)
            begin
                out_idx_q <= 4'h0;
                sum_snap_q <= summary;
                spi_sdo <= err_pend_q | summary[0];  // R8
            end
            else if (in_frame && sclk_rise && out_idx_q != 4'hf)
            begin
                out_idx_q <= out_idx_q + 4'h1;
                // read data is fixed here, before any commit: old value
                if (out_idx_q == 4'h7)
                begin
                    rdata_q <= rd_mux;  // R15
                    spi_sdo <= rd_mux[0];  // R23
                end
                else
                begin
                    spi_sdo <= out_word[out_idx_q + 4'h1];
                end
            end
        end
    end

    // a frame is decoded only at select rise, and only in live modes
    assign frame_good = cs_rise && bit_cnt_q == 5'(scf_pkg::FRAME_BITS)
        && !edge_err_q && !clk_s;  // R6 R7 R24
    assign accept = frame_good && (mode_q == scf_pkg::MODE_INIT
        || mode_q == scf_pkg::MODE_NORMAL || mode_q == scf_pkg::MODE_STOP);  // R12
    assign ctrl_wr = accept && c_wr && c_addr >= scf_pkg::ADDR_CTRL_LO
        && c_addr <= scf_pkg::ADDR_CTRL_HI;  // R11 R18
    assign no_wake = bus_control_one_q == 8'h00 && wake_two_q == 8'h00;

    // mode request checks and outside mode events
    always_comb
    begin
        mode_d = mode_q;
        fail = 1'b0;
        wr_ok = ctrl_wr;
        soft_rst = 1'b0;
        if (ctrl_wr && mode_q == scf_pkg::MODE_STOP)
        begin
            // only a trigger (same value) may touch the watchdog here
            if (c_addr == scf_pkg::ADDR_WATCHDOG)
            begin
                if (c_data != watchdog_config_q)
                begin
                    wr_ok = 1'b0;  // R3
                    fail = 1'b1;
                end
            end
            else if (c_addr != scf_pkg::ADDR_MODE_SUPPLY)
            begin
                wr_ok = 1'b0;  // R3
                fail = 1'b1;
            end
        end
        if (wr_ok && c_addr == scf_pkg::ADDR_MODE_SUPPLY)
        begin
            case (c_data[7:6])  // R25
                scf_pkg::MODE_CODE_NORMAL: mode_d = scf_pkg::MODE_NORMAL;
                scf_pkg::MODE_CODE_SLEEP:
                begin
                    fail = 1'b1;
                    if (mode_q == scf_pkg::MODE_INIT)
                    begin
                        mode_d = scf_pkg::MODE_NORMAL;  // R2
                    end
                    else if (mode_q == scf_pkg::MODE_STOP || no_wake)
                    begin
                        mode_d = scf_pkg::MODE_RESTART;  // R1 R4
                    end
                    else
                    begin
                        fail = 1'b0;
                        mode_d = scf_pkg::MODE_SLEEP;
                    end
                end
                scf_pkg::MODE_CODE_STOP:
                begin
                    if (mode_q == scf_pkg::MODE_INIT)
                    begin
                        fail = 1'b1;
                        mode_d = scf_pkg::MODE_NORMAL;  // R2
                    end
                    else
                    begin
                        mode_d = scf_pkg::MODE_STOP;  // R5
                    end
                end
                default:
                begin
                    soft_rst = 1'b1;
                    mode_d = scf_pkg::MODE_INIT;
                end
            endcase
        end
        else if (wr_ok && c_addr == scf_pkg::ADDR_WATCHDOG && mode_q == scf_pkg::MODE_INIT)
        begin
            mode_d = scf_pkg::MODE_NORMAL;
        end
        // events from the rest of the device
        if (failsafe_enter)
        begin
            mode_d = scf_pkg::MODE_FAILSAFE;
        end
        else if (mode_q == scf_pkg::MODE_FAILSAFE && failsafe_leave)
        begin
            mode_d = scf_pkg::MODE_RESTART;
        end
        else if (mode_q == scf_pkg::MODE_RESTART && restart_done)
        begin
            mode_d = scf_pkg::MODE_NORMAL;
        end
        else if (mode_q == scf_pkg::MODE_SLEEP && wake_event)
        begin
            mode_d = scf_pkg::MODE_RESTART;
        end
        else if (mode_q == scf_pkg::MODE_STOP && wake_event)
        begin
            mode_d = scf_pkg::MODE_NORMAL;
        end
    end

    // mode field tracks the mode actually held; init, restart and failsafe read as the normal code
    always_comb
    begin
        case (mode_q)
            scf_pkg::MODE_SLEEP: mode_code = scf_pkg::MODE_CODE_SLEEP;  // R20
            scf_pkg::MODE_STOP: mode_code = scf_pkg::MODE_CODE_STOP;
            default: mode_code = scf_pkg::MODE_CODE_NORMAL;
        endcase
    end

    // operating mode and one-cycle command pulses
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            mode_q <= scf_pkg::MODE_INIT;
            soft_reset_q <= 1'b0;
            watchdog_trigger_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            soft_reset_q <= soft_rst;
            watchdog_trigger_q <= wr_ok && c_addr == scf_pkg::ADDR_WATCHDOG;
        end
    end

    // an active transceiver field drops to wake-capable, others stay
    function automatic logic [1:0] to_wake(input logic [1:0] f);
        to_wake = (f == scf_pkg::TRX_ON) ? scf_pkg::TRX_WAKE : f;
    endfunction : to_wake

    // control registers: host writes, soft reset, sleep entry rewrite
    always_ff @(posedge clock)
    begin
        if (!reset_n || soft_rst)
        begin
            supply_misc_q <= scf_pkg::CTRL_RESET[2:0];
            auxiliary_supply_q <= scf_pkg::CTRL_RESET[4:3];
            hardware_config_q <= scf_pkg::CTRL_RESET;
            watchdog_config_q <= scf_pkg::CTRL_RESET;
            bus_control_one_q <= scf_pkg::CTRL_RESET;
            bus_control_two_q <= scf_pkg::CTRL_RESET;
            wake_one_q <= scf_pkg::CTRL_RESET;
            wake_two_q <= scf_pkg::CTRL_RESET;
            wake_pull_q <= scf_pkg::CTRL_RESET;
            timer_q <= scf_pkg::CTRL_RESET;
            scratch_q <= scf_pkg::CTRL_RESET;
        end
        else if (wr_ok)
        begin
            case (c_addr)  // R11 R27
                scf_pkg::ADDR_MODE_SUPPLY:
                begin
                    supply_misc_q <= c_data[2:0];
                    if (mode_q == scf_pkg::MODE_NORMAL)
                    begin
                        auxiliary_supply_q <= c_data[scf_pkg::AUX_LSB +: 2];  // R22
                    end
                end
                scf_pkg::ADDR_HW_CONFIG: hardware_config_q <= c_data;
                scf_pkg::ADDR_WATCHDOG: watchdog_config_q <= c_data;
                scf_pkg::ADDR_BUS_ONE: bus_control_one_q <= c_data;
                scf_pkg::ADDR_BUS_TWO: bus_control_two_q <= c_data;
                scf_pkg::ADDR_WAKE_ONE: wake_one_q <= c_data;
                scf_pkg::ADDR_WAKE_TWO: wake_two_q <= c_data;
                scf_pkg::ADDR_WAKE_PULL: wake_pull_q <= c_data;
                scf_pkg::ADDR_TIMER: timer_q <= c_data;
                scf_pkg::ADDR_SCRATCH: scratch_q <= c_data;
                default: timer_q <= timer_q;
            endcase
            // failsafe outputs live in the hardware byte, untouched here
            if (mode_d == scf_pkg::MODE_SLEEP && mode_q != scf_pkg::MODE_SLEEP)
            begin
                bus_control_one_q[1:0] <= to_wake(bus_control_one_q[1:0]);  // R21
                bus_control_one_q[4:3] <= to_wake(bus_control_one_q[4:3]);
                bus_control_two_q[1:0] <= to_wake(bus_control_two_q[1:0]);
                bus_control_two_q[4:3] <= to_wake(bus_control_two_q[4:3]);
                bus_control_two_q[7:6] <= to_wake(bus_control_two_q[7:6]);
            end
        end
    end

    // clear strobes for status registers addressed with the access bit
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            clr[i] = accept && c_wr && c_addr == scf_pkg::STAT_ADDR[i];  // R11 R18
        end
    end

    // sticky status: a set in the clearing cycle survives
    always_ff @(posedge clock)
    begin
        if (!reset_n)
        begin
            stat_q <= '0;
            stat_q[scf_pkg::STAT_SUPPLY] <= scf_pkg::SUPPLY_RESET;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                stat_q[i] <= (stat_q[i] & ~({8{clr[i]}})) | status_set[i];  // R13
            end
            if (fail)
            begin
                stat_q[scf_pkg::STAT_DEVICE][scf_pkg::CMD_FAIL_BIT] <= 1'b1;  // R26
            end
        end
    end

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    property p_stop_to_sleep;
        ctrl_wr && mode_q == scf_pkg::MODE_STOP && c_addr == scf_pkg::ADDR_MODE_SUPPLY
            && c_data[7:6] == scf_pkg::MODE_CODE_SLEEP && !failsafe_enter
            |=> mode_q == scf_pkg::MODE_RESTART && stat_q[2][1];
    endproperty
    a_stop_to_sleep: assert property (p_stop_to_sleep) // R1
        else $error("stop to sleep not refused");

    property p_init_low_power;
        ctrl_wr && mode_q == scf_pkg::MODE_INIT && c_addr == scf_pkg::ADDR_MODE_SUPPLY
            && c_data[7] != c_data[6] && !failsafe_enter |=> mode_q == scf_pkg::MODE_NORMAL;
    endproperty
    a_init_low_power: assert property (p_init_low_power) // R2
        else $error("init low power request not sent to normal");

    property p_sleep_no_wake;
        ctrl_wr && mode_q == scf_pkg::MODE_NORMAL && no_wake && !failsafe_enter
            && c_addr == scf_pkg::ADDR_MODE_SUPPLY && c_data[7:6] == scf_pkg::MODE_CODE_SLEEP
            |=> mode_q == scf_pkg::MODE_RESTART;
    endproperty
    a_sleep_no_wake: assert property (p_sleep_no_wake) // R4
        else $error("sleep without wake source accepted");

    property p_stop_accepted;
        ctrl_wr && mode_q == scf_pkg::MODE_NORMAL && !failsafe_enter
            && c_addr == scf_pkg::ADDR_MODE_SUPPLY && c_data[7:6] == scf_pkg::MODE_CODE_STOP
            |=> mode_q == scf_pkg::MODE_STOP && $stable(stat_q[2]);
    endproperty
    a_stop_accepted: assert property (p_stop_accepted) // R5
        else $error("stop request refused");

    property p_count_error;
        cs_rise && bit_cnt_q != 5'h00 && bit_cnt_q != 5'h10 |-> !accept ##1 err_pend_q;
    endproperty
    a_count_error: assert property (p_count_error) // R6
        else $error("clock count mismatch not flagged");

    property p_edge_error;
        cs_rise && clk_s |-> !accept ##1 err_pend_q;
    endproperty
    a_edge_error: assert property (p_edge_error) // R7
        else $error("clock high at select edge not flagged");

    property p_error_shown;
        cs_fall && err_pend_q |=> spi_sdo && !err_pend_q;
    endproperty
    a_error_shown: assert property (p_error_shown) // R8
        else $error("frame error not driven on data out");

    property p_empty_frame;
        cs_rise && bit_cnt_q == 5'h00 && !edge_err_q && !clk_s |=> !err_pend_q;
    endproperty
    a_empty_frame: assert property (p_empty_frame) // R9
        else $error("empty frame raised an error");

    property p_ignored_modes;
        cs_rise && (mode_q == scf_pkg::MODE_SLEEP || mode_q == scf_pkg::MODE_RESTART)
            |=> $stable(watchdog_config_q) && $stable(bus_control_one_q)
            && $stable(hardware_config_q);
    endproperty
    a_ignored_modes: assert property (p_ignored_modes) // R12
        else $error("register changed in an ignoring mode");

    property p_summary_clear;
        stat_q[0] == 8'h00 && cs_fall |=> !sum_snap_q[0];
    endproperty
    a_summary_clear: assert property (p_summary_clear) // R17
        else $error("summary bit set for empty register");
endmodule : scf_frontend

// >>> tb/scf_host.sv
// host spi master model driving the front end pins
`timescale 1ns/100ps
module scf_host (
    input wire logic clock,
    input wire logic spi_sdo,
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_sdi
);
    // idle: clock low, select high
    initial {spi_clk, spi_cs_n, spi_sdi} = 3'h2;
    // half a 160 ns link period, moved only at falling system clock edges
    task automatic hp;
        repeat (10) @(negedge clock);
    endtask : hp
    // frame of n clocks, lsb first; n may be 0 to peek at the error bit
    task automatic xfer(input logic [15:0] tx, input int n, input bit hi,
        output logic [15:0] rx);
        rx = 16'h0000;
        spi_cs_n = 1'h0;
        hp();
        rx[0] = spi_sdo;
        for (int i = 0; i < n; i++)
        begin
            rx[i] = spi_sdo;
            spi_sdi = tx[i];
            spi_clk = 1'h1;
            hp();
            spi_clk = 1'h0;
            hp();
        end
        // hi leaves the clock high across the select rise on purpose
        spi_clk = hi;
        spi_sdi = ~spi_sdi;
        hp();
        spi_cs_n = 1'h1;
        hp();
        spi_clk = 1'h0;
        hp();
    endtask : xfer
endmodule : scf_host

// >>> tb/scf_frontend_tb_top.sv
// testbench for the spi command front end
`timescale 1ns/100ps
module scf_frontend_tb_top;
    logic clock = 1'h0;
    logic reset_n = 1'h0;
    logic wake_event = 1'h0;
    logic restart_done = 1'h0;
    logic wake = 1'h0;
    logic oe_n;
    logic spi_clk, spi_cs_n, spi_sdi, spi_sdo;
    logic [7:0] bus_one;
    logic [15:0] rx;
    scf_pkg::scf_mode_t mode;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    always #4 clock = ~clock;
    // hang guard, well above the roughly 9700 cycles the run needs
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            failures++;
            end_of_test();
        end
    end
    scf_frontend uut (.clock(clock), .reset_n(reset_n), .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo), .spi_sdo_oe_n(oe_n),
        .wake_input(wake), .status_set(64'h0000_0000_0000_0000),
        .wake_event(wake_event), .restart_done(restart_done), .failsafe_enter(1'h0),
        .failsafe_leave(1'h0), .mode_q(mode), .soft_reset_q(), .watchdog_trigger_q(),
        .auxiliary_supply_q(), .hardware_config_q(), .watchdog_config_q(),
        .bus_control_one_q(bus_one), .bus_control_two_q());
    // a released data line shows the inverse, so a sample outside select fails
    scf_host host (.clock(clock), .spi_sdo(oe_n ? ~spi_sdo : spi_sdo), .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi));
    task automatic chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    // one access: address, access bit, data byte, clock count, clock high at select rise
    task automatic acc(input logic [6:0] a, input logic w, input logic [7:0] d,
        input int n = 16, input bit hi = 0);
        host.xfer({d, w, a}, n, hi, rx);
    endtask : acc
    // one-cycle wake (w=1) or restart-done (w=0) pulse
    task automatic kick(input logic w);
        wake_event = w;
        restart_done = ~w;
        @(negedge clock);
        {wake_event, restart_done} = 2'h0;
        @(negedge clock);
    endtask : kick
    task automatic end_of_test;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test
    initial
    begin
        repeat (2) @(negedge clock);
        reset_n = 1'h1;
        repeat (2) @(negedge clock);
        acc(7'h41, 1, 8'h00);
        chk("sup", rx, 16'h8001);
        acc(7'h41, 0, 8'h00);
        chk("sup", rx, 16'h0000);
        acc(7'h04, 1, 8'h03);
        acc(7'h01, 1, 8'h80);
        chk("mode", mode, scf_pkg::MODE_NORMAL);
        acc(7'h43, 1, 8'h00);
        chk("dev", rx, 16'h0204);
        $display("test frames and modes from init done");
        acc(7'h02, 1, 8'ha5);
        chk("hw", rx, 16'h0000);
        acc(7'h02, 1, 8'h11, 8);
        acc(7'h02, 0, 8'h00, 0);
        chk("err", rx, 16'h0001);
        acc(7'h02, 0, 8'h00, 0);
        chk("err", rx, 16'h0000);
        acc(7'h02, 1, 8'h22, 16, 1);
        acc(7'h02, 0, 8'h00);
        chk("hw", rx, 16'ha501);
        acc(7'h10, 1, 8'hff);
        chk("gap", rx, 16'h0000);
        wake = 1'h1;
        acc(7'h48, 1, 8'h00);
        chk("lvl", rx, 16'h0100);
        acc(7'h48, 1, 8'h00);
        chk("lvl", rx, 16'h0100);
        $display("test frame errors done");
        acc(7'h01, 1, 8'h80);
        acc(7'h01, 1, 8'h40);
        chk("mode", mode, scf_pkg::MODE_RESTART);
        acc(7'h02, 1, 8'h33);
        kick(1'h0);
        acc(7'h01, 0, 8'h00);
        chk("ms", rx, 16'h0004);
        acc(7'h02, 0, 8'h00);
        chk("hw", rx, 16'ha504);
        acc(7'h01, 1, 8'h40);
        chk("bus", bus_one, 16'h0001);
        kick(1'h1);
        kick(1'h0);
        acc(7'h04, 1, 8'h00);
        acc(7'h01, 1, 8'h80);
        chk("mode", mode, scf_pkg::MODE_STOP);
        acc(7'h01, 0, 8'h00);
        chk("ms", rx, 16'h8004);
        acc(7'h02, 1, 8'h5a);
        acc(7'h02, 0, 8'h00);
        chk("hw", rx, 16'ha504);
        acc(7'h01, 1, 8'h00);
        acc(7'h01, 1, 8'h40);
        chk("mode", mode, scf_pkg::MODE_RESTART);
        kick(1'h0);
        acc(7'h01, 1, 8'hc0);
        chk("mode", mode, scf_pkg::MODE_INIT);
        acc(7'h02, 0, 8'h00);
        chk("hw", rx, 16'h0004);
        $display("test mode requests done");
        end_of_test();
    end
endmodule : scf_frontend_tb_top
